/* src/pfmux_pkg.sv */
// How it works
// - Upper pins 5-7 carry wide data bits 13-15.
// - Config bit picks each aux pin's role.
// - Timer zero overflow gives one-cycle high pulse.
// - Split mode pulses on low-byte overflow.
// - Timer one pulse, split mode uses low byte.
// - Timer two overflow gives one-cycle pulse.
// - Serial zero data only in mode 0.
// - Serial one data only in mode 0.
// - Aux interrupt input captured on rising edge.
// - Trigger falling edge reloads timer two, when enabled.
// - Top aux pin drives wave address bit 8.
// - Read strobe polarity from polarity bit 3.
// - Write strobe polarity from polarity bit 2.
// - Ready pins zero/one shared with strobes by mode.
package pfmux_pkg;

  // ==========================================================================
  // Register map, byte-wide data.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_IF_CONFIG = 4'h0;
  localparam logic [3:0] OFS_EP_FIFO_CONFIG = 4'h1;
  localparam logic [3:0] OFS_AUX_PORT_CONFIG = 4'h2;
  localparam logic [3:0] OFS_FIFO_PIN_POLARITY = 4'h3;
  localparam logic [3:0] OFS_TIMER_TWO_CONTROL = 4'h4;
  localparam logic [3:0] OFS_UPPER_OUT = 4'h5;
  localparam logic [3:0] OFS_UPPER_DIR = 4'h6;
  localparam logic [3:0] OFS_AUX_OUT = 4'h7;
  localparam logic [3:0] OFS_AUX_DIR = 4'h8;
  localparam logic [3:0] OFS_UPPER_PINS = 4'h9;
  localparam logic [3:0] OFS_AUX_PINS = 4'hA;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'hB;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================================
  // Field positions.
  localparam int WORDWIDE_BIT = 0;
  localparam int POL_READ_BIT = 3;
  localparam int POL_WRITE_BIT = 2;
  localparam int EXT_ENABLE_BIT = 3;
  localparam int IRQ_AUX_EDGE_BIT = 0;
  localparam int IRQ_RELOAD_BIT = 1;
  localparam int AUX_T0 = 0;
  localparam int AUX_T1 = 1;
  localparam int AUX_T2 = 2;
  localparam int AUX_SER0 = 3;
  localparam int AUX_SER1 = 4;
  localparam int AUX_INT = 5;
  localparam int AUX_TRIG = 6;
  localparam int AUX_ADDR8 = 7;
  localparam int UPPER_W = 3;

  // ==========================================================================
  // Modes.
  typedef enum logic [1:0] {
    PFMUX_IF_PORTS = 2'b00,
    PFMUX_IF_RSVD = 2'b01,
    PFMUX_IF_WAVE = 2'b10,
    PFMUX_IF_SLAVE = 2'b11
  } pfmux_if_mode_e;
  localparam logic [1:0] TIMER_MODE_SPLIT = 2'h3;
  localparam logic [1:0] SERIAL_MODE_SYNC = 2'h0;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic ovf;
    logic low_ovf;
    logic [1:0] mode;
  } pfmux_timer_s;

  typedef struct packed {
    logic [1:0] mode;
    logic tx;
  } pfmux_serial_s;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pfmux_aux_drive_s;

  typedef struct packed {
    logic [2:0] dout;
    logic [2:0] oe;
  } pfmux_upper_drive_s;

endpackage

/* src/pfmux_port_pin_function_mux.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pfmux_port_pin_function_mux
  import pfmux_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire pfmux_timer_s timer_zero,
  input wire pfmux_timer_s timer_one,
  input wire logic timer_two_ovf,
  input wire pfmux_serial_s serial_zero,
  input wire pfmux_serial_s serial_one,
  input wire logic wave_addr8,
  input wire logic [UPPER_W-1:0] fifo_data_out,
  input wire logic [UPPER_W-1:0] fifo_data_oe,
  output logic [UPPER_W-1:0] fifo_data_in,
  input wire logic [UPPER_W-1:0] upper_port_pin_in,
  output pfmux_upper_drive_s upper_port_drive,
  input wire logic [7:0] aux_port_pin_in,
  output pfmux_aux_drive_s aux_port_drive,
  input wire logic [2:0] ready_pin_in,
  output logic [2:0] wave_ready,
  output logic slave_fifo_read_strobe,
  output logic slave_fifo_write_strobe,
  output logic aux_interrupt_request,
  output logic timer_two_reload
);

  // ==========================================================================
  // Registers.
  logic [1:0] interface_config;
  logic [7:0] endpoint_fifo_config;
  logic [7:0] aux_port_config;
  logic [7:0] fifo_pin_polarity;
  logic [7:0] timer_two_control;
  logic [UPPER_W-1:0] upper_out;
  logic [UPPER_W-1:0] upper_dir;
  logic [7:0] aux_out;
  logic [7:0] aux_dir;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] aux_pin_prev;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] irq_event;
  logic upper_is_bus;
  logic slave_mode;
  pfmux_aux_drive_s next_aux_drive;
  pfmux_upper_drive_s next_upper_drive;
  logic t0_src;
  logic t1_src;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      interface_config <= 2'h0;
      endpoint_fifo_config <= RESET_BYTE;
      aux_port_config <= RESET_BYTE;
      fifo_pin_polarity <= RESET_BYTE;
      timer_two_control <= RESET_BYTE;
      upper_out <= 3'h0;
      upper_dir <= 3'h0;
      aux_out <= RESET_BYTE;
      aux_dir <= RESET_BYTE;
      irq_mask <= 2'h0;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        OFS_IF_CONFIG: interface_config <= reg_wdata[1:0];
        OFS_EP_FIFO_CONFIG: endpoint_fifo_config <= reg_wdata;
        OFS_AUX_PORT_CONFIG: aux_port_config <= reg_wdata;
        OFS_FIFO_PIN_POLARITY: fifo_pin_polarity <= reg_wdata;
        OFS_TIMER_TWO_CONTROL: timer_two_control <= reg_wdata;
        OFS_UPPER_OUT: upper_out <= reg_wdata[7:5];
        OFS_UPPER_DIR: upper_dir <= reg_wdata[7:5];
        OFS_AUX_OUT: aux_out <= reg_wdata;
        OFS_AUX_DIR: aux_dir <= reg_wdata;
        OFS_IRQ_MASK: irq_mask <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data appears in the cycle after the strobe; unmapped reads give zero.
  always_comb
  begin
    next_rdata = RESET_BYTE;
    case (reg_addr)
      OFS_IF_CONFIG: next_rdata = {6'h00, interface_config};
      OFS_EP_FIFO_CONFIG: next_rdata = endpoint_fifo_config;
      OFS_AUX_PORT_CONFIG: next_rdata = aux_port_config;
      OFS_FIFO_PIN_POLARITY: next_rdata = fifo_pin_polarity;
      OFS_TIMER_TWO_CONTROL: next_rdata = timer_two_control;
      OFS_UPPER_OUT: next_rdata = {upper_out, 5'h00};
      OFS_UPPER_DIR: next_rdata = {upper_dir, 5'h00};
      OFS_AUX_OUT: next_rdata = aux_out;
      OFS_AUX_DIR: next_rdata = aux_dir;
      OFS_UPPER_PINS: next_rdata = {upper_port_pin_in, 5'h00};
      OFS_AUX_PINS: next_rdata = aux_port_pin_in;
      OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
      OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      default: next_rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= RESET_BYTE;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= RESET_BYTE;
  end

  // ==========================================================================
  // Input edge detection for the interrupt and reload roles.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      aux_pin_prev <= RESET_BYTE;
    else
      aux_pin_prev <= aux_port_pin_in;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aux_interrupt_request <= 1'b0;
      timer_two_reload <= 1'b0;
    end
    else
    begin
      aux_interrupt_request <= aux_port_config[AUX_INT] & aux_port_pin_in[AUX_INT] & ~aux_pin_prev[AUX_INT];
      timer_two_reload <= aux_port_config[AUX_TRIG] & timer_two_control[EXT_ENABLE_BIT]
        & ~aux_port_pin_in[AUX_TRIG] & aux_pin_prev[AUX_TRIG];
    end
  end

  // ==========================================================================
  // Interrupt status, set wins over a write-one clear.
  assign irq_event[IRQ_AUX_EDGE_BIT] = aux_interrupt_request;
  assign irq_event[IRQ_RELOAD_BIT] = timer_two_reload;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_status <= 2'h0;
    else if (reg_write && reg_addr == OFS_IRQ_STATUS)
      irq_status <= (irq_status & ~reg_wdata[1:0]) | irq_event;
    else
      irq_status <= irq_status | irq_event;
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================================
  // Auxiliary port pin functions.
  // split mode uses the low-byte overflow.
  assign t0_src = (timer_zero.mode == TIMER_MODE_SPLIT) ? timer_zero.low_ovf : timer_zero.ovf;
  assign t1_src = (timer_one.mode == TIMER_MODE_SPLIT) ? timer_one.low_ovf : timer_one.ovf;

  always_comb
  begin
    // plain port unless the config bit is set.
    next_aux_drive.dout = aux_out;
    next_aux_drive.oe = aux_dir;
    if (aux_port_config[AUX_T0])
    begin
      next_aux_drive.dout[AUX_T0] = t0_src;
      next_aux_drive.oe[AUX_T0] = 1'b1;
    end
    if (aux_port_config[AUX_T1])
    begin
      next_aux_drive.dout[AUX_T1] = t1_src;
      next_aux_drive.oe[AUX_T1] = 1'b1;
    end
    if (aux_port_config[AUX_T2])
    begin
      next_aux_drive.dout[AUX_T2] = timer_two_ovf;
      next_aux_drive.oe[AUX_T2] = 1'b1;
    end
    if (aux_port_config[AUX_SER0])
    begin
      next_aux_drive.dout[AUX_SER0] = (serial_zero.mode == SERIAL_MODE_SYNC) ? serial_zero.tx : 1'b1;
      next_aux_drive.oe[AUX_SER0] = 1'b1;
    end
    if (aux_port_config[AUX_SER1])
    begin
      next_aux_drive.dout[AUX_SER1] = (serial_one.mode == SERIAL_MODE_SYNC) ? serial_one.tx : 1'b1;
      next_aux_drive.oe[AUX_SER1] = 1'b1;
    end
    // Input roles release the pin.
    if (aux_port_config[AUX_INT])
      next_aux_drive.oe[AUX_INT] = 1'b0;
    if (aux_port_config[AUX_TRIG])
      next_aux_drive.oe[AUX_TRIG] = 1'b0;
    if (aux_port_config[AUX_ADDR8])
    begin
      next_aux_drive.dout[AUX_ADDR8] = wave_addr8;
      next_aux_drive.oe[AUX_ADDR8] = 1'b1;
    end
  end

  // ==========================================================================
  // Upper port pins 5 to 7.
  assign upper_is_bus = (interface_config != PFMUX_IF_PORTS) & endpoint_fifo_config[WORDWIDE_BIT];

  always_comb
  begin
    // wide bus bits or plain port.
    if (upper_is_bus)
    begin
      next_upper_drive.dout = fifo_data_out;
      next_upper_drive.oe = fifo_data_oe;
    end
    else
    begin
      next_upper_drive.dout = upper_out;
      next_upper_drive.oe = upper_dir;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aux_port_drive <= '0;
      upper_port_drive <= '0;
      fifo_data_in <= 3'h0;
    end
    else
    begin
      aux_port_drive <= next_aux_drive;
      upper_port_drive <= next_upper_drive;
      fifo_data_in <= upper_is_bus ? upper_port_pin_in : 3'h0;
    end
  end

  // ==========================================================================
  // Ready pins and slave strobes.
  assign slave_mode = (interface_config == PFMUX_IF_SLAVE);
  assign wave_ready = {ready_pin_in[2], slave_mode ? 2'b00 : ready_pin_in[1:0]};
  assign slave_fifo_read_strobe = slave_mode & ~(ready_pin_in[0] ^ fifo_pin_polarity[POL_READ_BIT]);
  assign slave_fifo_write_strobe = slave_mode & ~(ready_pin_in[1] ^ fifo_pin_polarity[POL_WRITE_BIT]);

  // ==========================================================================
  // Checks.
  sequence s_int_rise;
    aux_port_config[AUX_INT] && aux_port_pin_in[AUX_INT] && !aux_pin_prev[AUX_INT];
  endsequence

  sequence s_int_flag;
    aux_interrupt_request ##1 irq_status[IRQ_AUX_EDGE_BIT];
  endsequence

  sequence s_trig_fall;
    aux_port_config[AUX_TRIG] && timer_two_control[EXT_ENABLE_BIT]
      && !aux_port_pin_in[AUX_TRIG] && aux_pin_prev[AUX_TRIG];
  endsequence

  a_float_reset: assert property (@(posedge sys_clk) $fell(rst) |->
    (aux_port_drive.oe == 8'h00) && (upper_port_drive.oe == 3'h0))
    else $error("Pins driven right after reset.");

  a_t0_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_T0] && $stable(aux_port_config) |=> aux_port_drive.dout[AUX_T0] == $past(t0_src))
    else $error("Timer zero pulse does not follow overflow.");

  a_t0_split: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_T0] && timer_zero.mode == TIMER_MODE_SPLIT && timer_zero.low_ovf
    |=> aux_port_drive.dout[AUX_T0] && aux_port_drive.oe[AUX_T0])
    else $error("Split mode low overflow missed.");

  a_t1_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_T1] && !t1_src |=> !aux_port_drive.dout[AUX_T1])
    else $error("Timer one output high without overflow.");

  a_t2_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_T2] && timer_two_ovf && !$past(timer_two_ovf) ##1 !timer_two_ovf && aux_port_config[AUX_T2]
    |=> !aux_port_drive.dout[AUX_T2] && $past(aux_port_drive.dout[AUX_T2]))
    else $error("Timer two pulse not one cycle.");

  a_ser0_idle: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_SER0] && serial_zero.mode != SERIAL_MODE_SYNC |=> aux_port_drive.dout[AUX_SER0])
    else $error("Serial zero pin not high outside sync mode.");

  a_ser1_data: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_SER1] && serial_one.mode == SERIAL_MODE_SYNC
    |=> aux_port_drive.dout[AUX_SER1] == $past(serial_one.tx))
    else $error("Serial one sync data not on pin.");

  a_int_capture: assert property (@(posedge sys_clk) disable iff (rst)
    s_int_rise |=> s_int_flag)
    else $error("Aux interrupt edge not captured.");

  a_reload_edge: assert property (@(posedge sys_clk) disable iff (rst)
    timer_two_reload |-> $past(aux_port_pin_in[AUX_TRIG], 2) && !$past(aux_port_pin_in[AUX_TRIG])
    && $past(timer_two_control[EXT_ENABLE_BIT]))
    else $error("Reload without enabled falling edge.");

  a_reload_take: assert property (@(posedge sys_clk) disable iff (rst)
    s_trig_fall |=> timer_two_reload ##1 !timer_two_reload)
    else $error("Enabled falling edge did not reload once.");

  a_addr8_drive: assert property (@(posedge sys_clk) disable iff (rst)
    aux_port_config[AUX_ADDR8] |=> aux_port_drive.oe[AUX_ADDR8] && aux_port_drive.dout[AUX_ADDR8] == $past(wave_addr8))
    else $error("Address bit 8 not driven.");

  a_gpio_plain: assert property (@(posedge sys_clk) disable iff (rst)
    !aux_port_config[AUX_ADDR8] |=> aux_port_drive.oe[AUX_ADDR8] == $past(aux_dir[AUX_ADDR8]))
    else $error("Plain port direction not honoured.");

  a_strobe_pol: assert property (@(posedge sys_clk) disable iff (rst)
    slave_mode |-> slave_fifo_read_strobe == (ready_pin_in[0] == fifo_pin_polarity[POL_READ_BIT])
    && slave_fifo_write_strobe == (ready_pin_in[1] == fifo_pin_polarity[POL_WRITE_BIT]))
    else $error("Strobe polarity wrong.");

  a_ready_route: assert property (@(posedge sys_clk) disable iff (rst)
    !slave_mode |-> wave_ready == ready_pin_in && !slave_fifo_read_strobe && !slave_fifo_write_strobe)
    else $error("Ready pins misrouted.");

  a_upper_route: assert property (@(posedge sys_clk) disable iff (rst)
    interface_config == PFMUX_IF_PORTS |=> upper_port_drive.oe == $past(upper_dir))
    else $error("Upper pins left port mode.");

endmodule // pfmux_port_pin_function_mux

/* testbench/pfmux_far_model.sv */
`timescale 1ns/1ps
module pfmux_far_model
  import pfmux_pkg::*;
(
  input wire pfmux_upper_drive_s upper_drive,
  input wire pfmux_aux_drive_s aux_drive,
  input wire logic [2:0] ext_upper,
  input wire logic [7:0] ext_aux,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic wave_ready_in2,
  input wire logic [7:0] polarity,
  output logic [2:0] upper_pin,
  output logic [7:0] aux_pin,
  output logic [2:0] ready_pin
);
  // ==========================================================================
  // Pin resolution
  // shared pin level.
  // The far logic only drives a pin that the device has released.
  assign upper_pin = (upper_drive.oe & upper_drive.dout) | (~upper_drive.oe & ext_upper);
  assign aux_pin = (aux_drive.oe & aux_drive.dout) | (~aux_drive.oe & ext_aux);
  // strobe polarity.
  // Strobes are sent at the active level that the device is set to expect.
  assign ready_pin = {wave_ready_in2, polarity[POL_WRITE_BIT] ~^ wr_req, polarity[POL_READ_BIT] ~^ rd_req};
endmodule // pfmux_far_model

/* testbench/pfmux_port_pin_function_mux_bench.sv */
`timescale 1ns/1ps
module pfmux_port_pin_function_mux_bench
  import pfmux_pkg::*;
;
  logic sys_clk, rst, reg_write, reg_read, irq, t2ovf, wa8, rd_req, wr_req, wave_ready_in2, srd, swr, air, t2r;
  logic e_air, e_t2r, armed, slave, bus;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, aux_pin, ext_aux, q, alt, e_ad, e_aoe, sticky;
  logic [2:0] fdo, fdoe, fdi, up_pin, ext_up, wrdy, rdy, rdy_pin, e_ud, e_uoe, e_fdi;
  logic [7:0] rv [0:12];
  pfmux_timer_s t0, t1;
  pfmux_serial_s s0, s1;
  pfmux_upper_drive_s up_drv;
  pfmux_aux_drive_s aux_drv;
  int failures, tests_run;

  pfmux_port_pin_function_mux u_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .timer_zero(t0), .timer_one(t1),
    .timer_two_ovf(t2ovf), .serial_zero(s0), .serial_one(s1), .wave_addr8(wa8), .fifo_data_out(fdo),
    .fifo_data_oe(fdoe), .fifo_data_in(fdi), .upper_port_pin_in(up_pin), .upper_port_drive(up_drv),
    .aux_port_pin_in(aux_pin), .aux_port_drive(aux_drv), .ready_pin_in(rdy_pin), .wave_ready(wrdy),
    .slave_fifo_read_strobe(srd), .slave_fifo_write_strobe(swr), .aux_interrupt_request(air),
    .timer_two_reload(t2r)
  );

  pfmux_far_model u_far (
    .upper_drive(up_drv), .aux_drive(aux_drv), .ext_upper(ext_up), .ext_aux(ext_aux), .rd_req(rd_req),
    .wr_req(wr_req), .wave_ready_in2(wave_ready_in2), .polarity(rv[3]), .upper_pin(up_pin), .aux_pin(aux_pin), .ready_pin(rdy_pin)
  );

  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Compare and bus tasks
  task automatic chk_pin(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_reg(logic [7:0] exp);
    chk_pin("reg_rdata", exp, reg_rdata);
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge sys_clk);
    reg_write <= 1'h0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge sys_clk);
    reg_read <= 1'h0;
    #1;
    chk_reg(e);
    @(posedge sys_clk);
    #1;
    chk_reg(8'h00);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // One random cycle: checks last cycle's expectation, then predicts the next.
  task automatic step();
    @(posedge sys_clk);
    {t0, t1, t2ovf, s0, s1, wa8} <= 16'($urandom);
    {fdo, fdoe, ext_up, rd_req, wr_req, wave_ready_in2} <= 12'($urandom);
    ext_aux <= 8'($urandom);
    #1;
    if (armed)
    begin
      chk_pin("aux_oe", e_aoe, aux_drv.oe);
      chk_pin("aux_dout", e_ad & e_aoe, aux_drv.dout & e_aoe);
      chk_pin("upper_oe", 8'(e_uoe), 8'(up_drv.oe));
      chk_pin("upper_dout", 8'(e_ud & e_uoe), 8'(up_drv.dout & e_uoe));
      chk_pin("fifo_data_in", 8'(e_fdi), 8'(fdi));
      chk_pin("aux_irq_req", 8'(e_air), 8'(air));
      chk_pin("t2_reload", 8'(e_t2r), 8'(t2r));
      sticky |= 8'({e_t2r, e_air});
    end
    slave = rv[0][1:0] == 2'h3;
    rdy = {wave_ready_in2, rv[3][2] ~^ wr_req, rv[3][3] ~^ rd_req};
    chk_pin("wave_ready", {5'h0, rdy[2], slave ? 2'h0 : rdy[1:0]}, 8'(wrdy));
    chk_pin("strobes", {6'h0, slave & wr_req, slave & rd_req}, {6'h0, swr, srd});
    alt = {wa8, 2'h0, s1.mode == SERIAL_MODE_SYNC ? s1.tx : 1'h1, s0.mode == SERIAL_MODE_SYNC ? s0.tx : 1'h1,
           t2ovf, t1.mode == TIMER_MODE_SPLIT ? t1.low_ovf : t1.ovf, t0.mode == TIMER_MODE_SPLIT ? t0.low_ovf : t0.ovf};
    e_aoe = (rv[2] & 8'h9F) | (~rv[2] & rv[8]);
    e_ad = (rv[2] & alt) | (~rv[2] & rv[7]);
    bus = rv[0][1:0] != 2'h0 && rv[1][0];
    e_uoe = bus ? fdoe : rv[6][7:5];
    e_ud = bus ? fdo : rv[5][7:5];
    e_fdi = bus ? up_pin : 3'h0;
    e_air = rv[2][5] & aux_pin[5] & ~q[5];
    e_t2r = rv[2][6] & rv[4][3] & ~aux_pin[6] & q[6];
    q = aux_pin;
    armed = 1'h1;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    {t0, t1, t2ovf, s0, s1, wa8, fdo, fdoe, ext_up, rd_req, wr_req, wave_ready_in2, ext_aux} = '0;
    {reg_addr, reg_wdata, reg_write, reg_read, armed, sticky} = '0;
    foreach (rv[a]) rv[a] = 8'h00;
    rst = 1'h1;
    void'($urandom(78));
    repeat (3) @(posedge sys_clk);
    #1;
    chk_pin("oe_in_reset", 8'h00, aux_drv.oe | 8'(up_drv.oe));
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk_pin("oe_after_reset", 8'h00, aux_drv.oe | 8'(up_drv.oe));
    for (int a = 0; a < 13; a++)
      if (a != 9 && a != 10) rd(4'(a), 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      foreach (rv[a]) rv[a] = 8'($urandom);
      rv[0] = 8'(k % 4);
      rv[1] = 8'(k / 4);
      rv[2] = k == 0 ? 8'hFF : k == 1 ? 8'h00 : rv[2];
      rv[3] &= 8'h0C;
      rv[4] &= 8'h08;
      rv[12] &= 8'h03;
      for (int a = 0; a < 9; a++) wr(4'(a), rv[a]);
      wr(OFS_IRQ_MASK, rv[12]);
      for (int a = 0; a < 13; a++)
        if (a != 9 && a != 10 && a != 11) rd(4'(a), (a == 5 || a == 6) ? rv[a] & 8'hE0 : rv[a]);
      repeat (3) @(posedge sys_clk);
      wr(OFS_IRQ_STATUS, 8'h03);
      rd(OFS_IRQ_STATUS, 8'h00);
      sticky = 8'h00;
      armed = 1'h0;
      q = aux_pin;
      repeat (30) step();
      sticky |= 8'({e_t2r, e_air});
      repeat (3) @(posedge sys_clk);
      rd(OFS_AUX_PINS, aux_pin);
      rd(OFS_UPPER_PINS, {up_pin, 5'h00});
      rd(OFS_IRQ_STATUS, sticky);
      chk_pin("irq", 8'(|(sticky & rv[12])), 8'(irq));
      wr(OFS_IRQ_STATUS, 8'h01);
      rd(OFS_IRQ_STATUS, sticky & 8'h02);
      chk_pin("irq_cleared", 8'(|(sticky & rv[12] & 8'h02)), 8'(irq));
    end
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'h00);
    rd(4'hF, 8'h00);
    end_of_test();
  end

  // The tests need under 1200 cycles; allow about eight times that before cutting a hang.
  initial
  begin
    #50000;
    failures++;
    end_of_test();
  end
endmodule // pfmux_port_pin_function_mux_bench
